// ===== rtl/ccb_pkg.sv
// Constants for the compare blocking and pair unit
// Assumes a 32-bit AXI4-Lite master and two timers advanced by strobes
package ccb_pkg;

    // ********************************************
    // Sizes
    // ********************************************
    localparam int NCH    = 16;
    localparam int NPAIR  = 8;
    localparam int NTMR   = 2;
    localparam int CMP_W  = 16;
    localparam int ADDR_W = 7;
    localparam int NIRQ   = 18;

    // ********************************************
    // Register byte offsets
    // ********************************************
    localparam logic [6:0] OFS_TMR0_CNT = 7'h00;
    localparam logic [6:0] OFS_TMR0_RLD = 7'h04;
    localparam logic [6:0] OFS_TMR1_CNT = 7'h08;
    localparam logic [6:0] OFS_TMR1_RLD = 7'h0C;
    localparam logic [6:0] OFS_MODE     = 7'h10;
    localparam logic [6:0] OFS_ALLOC    = 7'h14;
    localparam logic [6:0] OFS_PAIR     = 7'h18;
    localparam logic [6:0] OFS_OUT      = 7'h1C;
    localparam logic [6:0] OFS_STATUS   = 7'h20;
    localparam logic [6:0] OFS_MASK     = 7'h24;
    localparam logic [6:0] OFS_CMP      = 7'h40;

    // ********************************************
    // Field positions and reset values
    // ********************************************
    localparam int IRQ_OVF_POS = 16;
    localparam logic [15:0] RST_CMP   = 16'h0000;
    localparam logic [15:0] RST_TMR   = 16'h0000;
    localparam logic [31:0] RST_MODE  = 32'h0000_0000;
    localparam logic [15:0] RST_ALLOC = 16'h0000;
    localparam logic [15:0] RST_PAIR  = 16'h0000;
    localparam logic [17:0] RST_MASK  = 18'h0_0000;

    // ********************************************
    // Codes
    // ********************************************
    localparam logic [1:0] MODE_IRQ      = 2'h0;
    localparam logic [1:0] MODE_TOGGLE   = 2'h1;
    localparam logic [1:0] MODE_ONCE_IRQ = 2'h2;
    localparam logic [1:0] MODE_PWM      = 2'h3;
    localparam logic [1:0] PAIR_COMPAT   = 2'h0;
    localparam logic [1:0] PAIR_OFF      = 2'h1;
    localparam logic [1:0] PAIR_ON       = 2'h2;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage

// ===== rtl/ccb_timer.sv
// Reloading up-counter allocated to compare channels
// Assumes inc and software writes are synchronous to clk
`timescale 1ns/100ps
module ccb_timer
    import ccb_pkg::*;
#(
    parameter int W = CMP_W
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Control
    input  wire logic         inc,
    input  wire logic         wr_cnt,
    input  wire logic         wr_rld,
    input  wire logic [W-1:0] wdata,
    // State
    output logic      [W-1:0] cnt,
    output logic      [W-1:0] rld,
    output logic              cmp_en,
    output logic              ovf
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] rld;
        logic         cmp_en;
        logic         ovf;
    } ccb_timer_state_type;

    ccb_timer_state_type r_reg;
    ccb_timer_state_type r_next;

    // ********************************************
    // Counter
    // ********************************************
    always_comb
    begin
        r_next        = r_reg;
        r_next.cmp_en = 1'b0;
        r_next.ovf    = 1'b0;
        if (wr_rld)
        begin
            r_next.rld = wdata;
        end
        if (wr_cnt)
        begin
            r_next.cnt = wdata;
        end
        else if (inc)
        begin
            r_next.cmp_en = 1'b1;
            if (r_reg.cnt == {W{1'b1}})
            begin
                r_next.cnt = r_reg.rld;
                r_next.ovf = 1'b1;
            end
            else
            begin
                r_next.cnt = r_reg.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r_reg <= '{cnt: W'(RST_TMR), rld: W'(RST_TMR), cmp_en: 1'b0, ovf: 1'b0};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign cnt    = r_reg.cnt;
    assign rld    = r_reg.rld;
    assign cmp_en = r_reg.cmp_en;
    assign ovf    = r_reg.ovf;

    // ********************************************
    // Checks
    // ********************************************
    property p_wrap;
        @(posedge clk) disable iff (rst)
        inc && !wr_cnt && !wr_rld && (r_reg.cnt == {W{1'b1}}) |=> ovf && (cnt == $past(rld));
    endproperty
    a_wrap: assert property (p_wrap) else $error("Timer did not restart at reload");

    property p_en;
        @(posedge clk) disable iff (rst)
        cmp_en |-> $past(inc) && !$past(wr_cnt);
    endproperty
    a_en: assert property (p_en) else $error("Compare enabled without increment");

endmodule

// ===== rtl/ccb_unit.sv
// Sixteen compare channels with blocking modes and bank pairing
// Assumes an AXI4-Lite master and timer increment strobes on TMR_INC
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps

// Summary of operation
// - Timer restarts from reload after overflow
// - Mode 3 match sets output, overflow clears
// - Timer overflow raises its own interrupt
// - Modes 2,3 block further matches until overflow
// - Modes 2,3: value written after match applies next period
// - Mode 2 interrupt only; mode 3 drives output
// - Early rewrite replaces the pending match
// - Match at rewrite time still counts
// - Compare equal reload keeps output high
// - Compare below reload never matches
// - Channels split into two banks of eight
// - Channel x pairs with channel x+8
// - Paired matches drive lower bank pin only
// - Pairing via field or mode combination
// - Field 00 compat, 01 off, 10 on
// - Compat pairing: lower mode 1, upper 0
// - Paired match raises own interrupt, toggles
// - Simultaneous pair matches toggle once
module ccb_unit
    import ccb_pkg::*;
#(
    parameter int CW = CMP_W
)
(
    // Clock and reset
    input  wire logic              SYS_CLK,
    input  wire logic              RST,
    // Timer increment strobes
    input  wire logic [NTMR-1:0]   TMR_INC,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    // Channel outputs
    output logic [NCH-1:0]         CHANNEL_OUTPUT_PIN,
    output logic [NCH-1:0]         CHANNEL_MATCH_IRQ,
    output logic [NTMR-1:0]        TIMER_OVERFLOW_IRQ,
    output logic                   INTERRUPT
);

    typedef struct packed {
        logic                          aw_hold;
        logic [ADDR_W-1:0]             aw_addr;
        logic                          awready;
        logic                          w_hold;
        logic [31:0]                   w_data;
        logic [3:0]                    w_strb;
        logic                          wready;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          arready;
        logic                          rvalid;
        logic [31:0]                   rdata;
        logic [1:0]                    rresp;
        logic [NCH-1:0][CW-1:0]        cmp;
        logic [NCH-1:0][1:0]           mode;
        logic [NCH-1:0]                alloc;
        logic [NPAIR-1:0][1:0]         pair;
        logic [NCH-1:0]                out;
        logic [NCH-1:0]                blocked;
        logic [NIRQ-1:0]               status;
        logic [NIRQ-1:0]               mask;
        logic [NCH-1:0]                ch_irq;
        logic [NTMR-1:0]               ovf_irq;
        logic                          irq;
    } ccb_state_type;

    ccb_state_type              s_reg;
    ccb_state_type              s_next;
    logic [NTMR-1:0][CW-1:0]    tmr_cnt;
    logic [NTMR-1:0][CW-1:0]    tmr_rld;
    logic [NTMR-1:0]            tmr_en;
    logic [NTMR-1:0]            tmr_ovf;
    logic [NTMR-1:0]            tmr_wr_cnt;
    logic [NTMR-1:0]            tmr_wr_rld;
    logic [CW-1:0]              tmr_wdata;
    logic [NCH-1:0]             ev;
    logic [NCH-1:0]             ch_ovf;
    logic [NPAIR-1:0]           dr;
    logic [31:0]                wdm;
    logic [31:0]                wclr;
    logic                       wr_go;

    // ********************************************
    // Timers
    // ********************************************
    for (genvar t = 0; t < NTMR; t++)
    begin : g_tmr
        ccb_timer #(.W(CW)) u_tmr (
            .clk    (SYS_CLK),
            .rst    (RST),
            .inc    (TMR_INC[t]),
            .wr_cnt (tmr_wr_cnt[t]),
            .wr_rld (tmr_wr_rld[t]),
            .wdata  (tmr_wdata),
            .cnt    (tmr_cnt[t]),
            .rld    (tmr_rld[t]),
            .cmp_en (tmr_en[t]),
            .ovf    (tmr_ovf[t])
        );
    end

    // ********************************************
    // Register access helpers
    // ********************************************
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return (a >= OFS_CMP) || (a <= OFS_MASK);
    endfunction

    function automatic logic [31:0] reg_value(input logic [ADDR_W-1:0] a);
        logic [31:0] v;
        v = '0;
        if (a >= OFS_CMP)
        begin
            v[CW-1:0] = s_reg.cmp[a[5:2]];
        end
        else
        begin
            case (a)
                OFS_TMR0_CNT: v[CW-1:0] = tmr_cnt[0];
                OFS_TMR0_RLD: v[CW-1:0] = tmr_rld[0];
                OFS_TMR1_CNT: v[CW-1:0] = tmr_cnt[1];
                OFS_TMR1_RLD: v[CW-1:0] = tmr_rld[1];
                OFS_MODE:     v = s_reg.mode;
                OFS_ALLOC:    v[NCH-1:0] = s_reg.alloc;
                OFS_PAIR:     v[2*NPAIR-1:0] = s_reg.pair;
                OFS_OUT:      v[NCH-1:0] = s_reg.out;
                OFS_STATUS:   v[NIRQ-1:0] = s_reg.status;
                OFS_MASK:     v[NIRQ-1:0] = s_reg.mask;
                default:      v = '0;
            endcase
        end
        return v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] st);
        logic [31:0] m;
        m = o;
        for (int b = 0; b < 4; b++)
        begin
            if (st[b])
            begin
                m[8*b +: 8] = n[8*b +: 8];
            end
        end
        return m;
    endfunction

    // ********************************************
    // Next state
    // ********************************************
    always_comb
    begin
        s_next     = s_reg;
        tmr_wr_cnt = '0;
        tmr_wr_rld = '0;
        wr_go      = s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid;
        wdm        = merge(reg_value(s_reg.aw_addr), s_reg.w_data, s_reg.w_strb);
        wclr       = merge(32'h0000_0000, s_reg.w_data, s_reg.w_strb);
        tmr_wdata  = wdm[CW-1:0];
        // Write channel
        if (S_AXI_AWVALID && s_reg.awready)
        begin
            s_next.aw_hold = 1'b1;
            s_next.aw_addr = {S_AXI_AWADDR[ADDR_W-1:2], 2'b00};
        end
        if (S_AXI_WVALID && s_reg.wready)
        begin
            s_next.w_hold = 1'b1;
            s_next.w_data = S_AXI_WDATA;
            s_next.w_strb = S_AXI_WSTRB;
        end
        if (s_reg.bvalid && S_AXI_BREADY)
        begin
            s_next.bvalid = 1'b0;
        end
        if (wr_go)
        begin
            s_next.aw_hold = 1'b0;
            s_next.w_hold  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = mapped(s_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (s_reg.aw_addr >= OFS_CMP)
            begin
                // new value replaces the pending one
                s_next.cmp[s_reg.aw_addr[5:2]] = wdm[CW-1:0];
            end
            else
            begin
                case (s_reg.aw_addr)
                    OFS_TMR0_CNT: tmr_wr_cnt[0] = 1'b1;
                    OFS_TMR0_RLD: tmr_wr_rld[0] = 1'b1;
                    OFS_TMR1_CNT: tmr_wr_cnt[1] = 1'b1;
                    OFS_TMR1_RLD: tmr_wr_rld[1] = 1'b1;
                    OFS_MODE:     s_next.mode = wdm;
                    OFS_ALLOC:    s_next.alloc = wdm[NCH-1:0];
                    OFS_PAIR:     s_next.pair = wdm[2*NPAIR-1:0];
                    OFS_STATUS:   s_next.status = s_reg.status & ~wclr[NIRQ-1:0];
                    OFS_MASK:     s_next.mask = wdm[NIRQ-1:0];
                    default:      s_next.bresp = s_next.bresp;
                endcase
            end
        end
        s_next.awready = !s_next.aw_hold;
        s_next.wready  = !s_next.w_hold;
        // Read channel
        if (S_AXI_ARVALID && s_reg.arready)
        begin
            s_next.rvalid = 1'b1;
            s_next.rdata  = reg_value({S_AXI_ARADDR[ADDR_W-1:2], 2'b00});
            s_next.rresp  = mapped({S_AXI_ARADDR[ADDR_W-1:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_reg.rvalid && S_AXI_RREADY)
        begin
            s_next.rvalid = 1'b0;
        end
        s_next.arready = !s_next.rvalid;

        // Matches use the compare value held before this cycle's write
        for (int c = 0; c < NCH; c++)
        begin
            ch_ovf[c] = tmr_ovf[s_reg.alloc[c]];
            ev[c] = tmr_en[s_reg.alloc[c]] && (tmr_cnt[s_reg.alloc[c]] == s_reg.cmp[c])
                    && !(s_reg.mode[c][1] && s_reg.blocked[c] && !ch_ovf[c]);
            if (ch_ovf[c])
            begin
                s_next.blocked[c] = 1'b0;
            end
            // later writes wait for next period
            if (ev[c] && s_reg.mode[c][1])
            begin
                s_next.blocked[c] = 1'b1;
            end
        end

        // lower bank 0..7, upper bank 8..15
        for (int p = 0; p < NPAIR; p++)
        begin
            dr[p] = (s_reg.pair[p] == PAIR_ON)
                    || ((s_reg.pair[p] == PAIR_COMPAT) && (s_reg.mode[p] == MODE_TOGGLE)
                        && (s_reg.mode[p+NPAIR] == MODE_IRQ));
        end

        for (int c = 0; c < NCH; c++)
        begin
            if ((c < NPAIR) && dr[c % NPAIR])
            begin
                if (ev[c] || ev[(c % NPAIR) + NPAIR])
                begin
                    s_next.out[c] = !s_reg.out[c];
                end
            end
            else if ((c >= NPAIR) && dr[c % NPAIR])
            begin
                s_next.out[c] = s_reg.out[c];
            end
            else
            begin
                // modes 0 and 2 leave the output alone
                if ((s_reg.mode[c] == MODE_TOGGLE) && ev[c])
                begin
                    s_next.out[c] = !s_reg.out[c];
                end
                if (s_reg.mode[c] == MODE_PWM)
                begin
                    if (ch_ovf[c])
                    begin
                        s_next.out[c] = 1'b0;
                    end
                    if (ev[c])
                    begin
                        s_next.out[c] = 1'b1;
                    end
                end
            end
        end

        s_next.ch_irq  = ev;
        s_next.ovf_irq = tmr_ovf;
        s_next.status  = s_next.status | {tmr_ovf, ev};
        s_next.irq     = |(s_next.status & s_next.mask);
    end

    // ********************************************
    // State register
    // ********************************************
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            s_reg         <= '0;
            s_reg.awready <= 1'b1;
            s_reg.wready  <= 1'b1;
            s_reg.arready <= 1'b1;
            s_reg.cmp     <= {NCH{CW'(RST_CMP)}};
            s_reg.mode    <= RST_MODE;
            s_reg.alloc   <= RST_ALLOC;
            s_reg.pair    <= RST_PAIR;
            s_reg.mask    <= RST_MASK;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign S_AXI_AWREADY      = s_reg.awready;
    assign S_AXI_WREADY       = s_reg.wready;
    assign S_AXI_BVALID       = s_reg.bvalid;
    assign S_AXI_BRESP        = s_reg.bresp;
    assign S_AXI_ARREADY      = s_reg.arready;
    assign S_AXI_RVALID       = s_reg.rvalid;
    assign S_AXI_RDATA        = s_reg.rdata;
    assign S_AXI_RRESP        = s_reg.rresp;
    assign CHANNEL_OUTPUT_PIN = s_reg.out;
    assign CHANNEL_MATCH_IRQ  = s_reg.ch_irq;
    assign TIMER_OVERFLOW_IRQ = s_reg.ovf_irq;
    assign INTERRUPT          = s_reg.irq;

    // ********************************************
    // Checks
    // ********************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    sequence s_pwm_hit;
        ev[0] && (s_reg.mode[0] == MODE_PWM) && !dr[0];
    endsequence
    sequence s_pwm_ovf;
        ch_ovf[0] && !ev[0] && (s_reg.mode[0] == MODE_PWM) && !dr[0];
    endsequence

    property p_pwm_set;
        s_pwm_hit |=> CHANNEL_OUTPUT_PIN[0] && CHANNEL_MATCH_IRQ[0];
    endproperty
    a_pwm_set: assert property (p_pwm_set) else $error("Mode 3 match did not set output");

    property p_pwm_clear;
        s_pwm_ovf |=> !CHANNEL_OUTPUT_PIN[0];
    endproperty
    a_pwm_clear: assert property (p_pwm_clear) else $error("Overflow did not clear output");

    property p_ovf_irq;
        tmr_ovf[0] |=> TIMER_OVERFLOW_IRQ[0] && s_reg.status[IRQ_OVF_POS];
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("Overflow interrupt missing");

    property p_block;
        s_reg.blocked[0] && s_reg.mode[0][1] && !ch_ovf[0] |=> !CHANNEL_MATCH_IRQ[0];
    endproperty
    a_block: assert property (p_block) else $error("Blocked channel matched");

    property p_block_set;
        ev[0] && s_reg.mode[0][1] ##1 !ch_ovf[0] |-> s_reg.blocked[0];
    endproperty
    a_block_set: assert property (p_block_set) else $error("Match did not block");

    property p_quiet;
        (s_reg.mode[1] == MODE_ONCE_IRQ) && !dr[1] |=> $stable(CHANNEL_OUTPUT_PIN[1]);
    endproperty
    a_quiet: assert property (p_quiet) else $error("Mode 2 changed the output");

    property p_compat;
        (s_reg.pair[4] == PAIR_COMPAT) && (s_reg.mode[4] == MODE_TOGGLE) && (s_reg.mode[12] == MODE_IRQ) && ev[12]
            |=> CHANNEL_OUTPUT_PIN[4] != $past(CHANNEL_OUTPUT_PIN[4]);
    endproperty
    a_compat: assert property (p_compat) else $error("Compat pairing not applied");

    property p_pair_toggle;
        dr[5] && (ev[5] || ev[13]) |=> CHANNEL_OUTPUT_PIN[5] != $past(CHANNEL_OUTPUT_PIN[5]);
    endproperty
    a_pair_toggle: assert property (p_pair_toggle) else $error("Pair output not toggled once");

    property p_dual_irq;
        ev[5] && ev[13] |=> CHANNEL_MATCH_IRQ[5] && CHANNEL_MATCH_IRQ[13];
    endproperty
    a_dual_irq: assert property (p_dual_irq) else $error("Pair interrupts not both raised");

    property p_irq_level;
        INTERRUPT == |(s_reg.status & s_reg.mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt level mismatch");

endmodule

// ===== verif/ccb_irq_sink.sv
// Partner model: interrupt controller counting interrupt assertions
// Assumes the interrupt level is synchronous to clk
`timescale 1ns/100ps
module ccb_irq_sink
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Interrupt level
    input  wire logic irq,
    output int        edges
);
    logic last;
    always_ff @(posedge clk)
    begin
        last <= irq;
        if (rst)
            edges <= 0;
        else if (irq && !last)
            edges <= edges + 1;
    end
endmodule

// ===== verif/test_ccb_unit.sv
// Bench for the compare blocking and pair unit
// Assumes one 200 MHz clock and AXI4-Lite register access
`timescale 1ns/100ps
module test_ccb_unit;
    import ccb_pkg::*;
    typedef struct packed {logic [15:0] pin; logic [15:0] irq; logic [1:0] ovf;} ccb_row_type;
    logic        clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, awr, wr_r, bv, arr, rv, intr;
    logic [1:0]  inc = 0, bresp, rresp, ovf_irq;
    logic [6:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, rdat;
    logic [1:0]  brsp, rrsp;
    logic [3:0]  ws = 4'hF;
    logic [15:0] pins, match, acc;
    logic [1:0]  oacc;
    int          num_errors = 0, cmp_count = 0, edges;
    ccb_row_type rows [8] = '{'{16'h0004, 16'h0004, 2'h0}, '{16'h0014, 16'h0010, 2'h0},
        '{16'h0074, 16'h2060, 2'h0}, '{16'h0075, 16'h0003, 2'h0}, '{16'h0065, 16'h1000, 2'h0},
        '{16'h0065, 16'h4000, 2'h0}, '{16'h0065, 16'h0000, 2'h0}, '{16'h0064, 16'h0004, 2'h1}};
    ccb_unit u_ccb_unit (.SYS_CLK(clk), .RST(rst), .TMR_INC(inc), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
        .CHANNEL_OUTPUT_PIN(pins), .CHANNEL_MATCH_IRQ(match), .TIMER_OVERFLOW_IRQ(ovf_irq), .INTERRUPT(intr));
    ccb_irq_sink u_ccb_irq_sink (.clk(clk), .rst(rst), .irq(intr), .edges(edges));
    always #2.5 clk = ~clk;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task stop_test;
    begin
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    task wr(input logic [6:0] a, input logic [31:0] d);
        logic ta, tw, tbv;
    begin
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
        do
        begin
            #1;
            ta = awr; tw = wr_r; tbv = bv; brsp = bresp;
            @(posedge clk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
        end while (tbv !== 1'b1);
        br <= 0;
    end
    endtask
    task rdr(input logic [6:0] a);
        logic ta, tbv;
    begin
        @(posedge clk);
        ara <= a; arv <= 1; rr <= 1;
        do
        begin
            #1;
            ta = arr; tbv = rv; rdat = rd; rrsp = rresp;
            @(posedge clk);
            if (ta) arv <= 0;
        end while (tbv !== 1'b1);
        rr <= 0;
    end
    endtask
    task run(input int n);
    begin
        acc = 0; oacc = 0;
        repeat (n)
        begin
            @(posedge clk); inc <= 2'b01;
            @(posedge clk); inc <= 2'b00;
            repeat (3)
            begin
                @(posedge clk); #1;
                acc |= match; oacc |= ovf_irq;
            end
        end
    end
    endtask
    initial
    begin
        #200us;
        num_errors++;
        stop_test;
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 0;
        @(posedge clk); #1;
        chk(pins, 0);
        rdr(OFS_MODE); chk(rdat, RST_MODE);
        rdr(7'h28); chk(rrsp, RESP_SLVERR); chk(rdat, 0);
        wr(OFS_TMR0_RLD, 32'h0000_FFF9); wr(OFS_TMR0_CNT, 32'h0000_FFF8);
        wr(OFS_MODE, 32'h0000_15FB); wr(OFS_PAIR, 32'h0000_1800);
        foreach (rows[i]) ; 
        wr(OFS_CMP, 32'h0000_FFFC); wr(OFS_CMP + 4, 32'h0000_FFFC); wr(OFS_CMP + 8, 32'h0000_FFF9);
        wr(OFS_CMP + 12, 32'h0000_FFF8); wr(OFS_CMP + 16, 32'h0000_FFFA); wr(OFS_CMP + 20, 32'h0000_FFFB);
        wr(OFS_CMP + 24, 32'h0000_FFFB); wr(OFS_CMP + 48, 32'h0000_FFFD); wr(OFS_CMP + 52, 32'h0000_FFFB);
        wr(OFS_CMP + 56, 32'h0000_FFFE);
        chk(match, 0);
        for (int i = 0; i < 8; i++)
        begin
            run(1);
            chk(pins, rows[i].pin);
            chk(acc, rows[i].irq);
            chk(oacc, rows[i].ovf);
        end
        $display("Row table done");
        wr(OFS_OUT, 32'h0000_FFFF); chk(brsp, RESP_OKAY);
        wr(7'h28, 32'h0000_FFFF); chk(brsp, RESP_SLVERR);
        rdr(OFS_OUT); chk(rdat, 32'h0000_0064);
        chk(intr, 0);
        wr(OFS_MASK, 32'h0003_0000); repeat (2) @(posedge clk); #1;
        chk(intr, 1);
        ws <= 4'h4; wr(OFS_STATUS, 32'h0003_FFFF); repeat (2) @(posedge clk); #1;
        chk(intr, 0); chk(edges, 1);
        rdr(OFS_STATUS); chk(rdat, 32'h0000_7077);
        ws <= 4'hF; wr(OFS_STATUS, 32'h0003_FFFF);
        rdr(OFS_STATUS); chk(rdat, 0);
        $display("Interrupt test done");
        run(3); chk(pins[0], 1); chk(acc[0], 1);
        wr(OFS_CMP, 32'h0000_FFFE);
        run(2); chk(acc[0], 0);
        run(2); chk(pins[0], 0);
        run(3); chk(acc[0], 0);
        run(2); chk(acc[0], 1); chk(pins[0], 1);
        $display("Blocking test done");
        wr(OFS_ALLOC, 32'h0000_8000); wr(OFS_TMR1_CNT, 32'h0000_FFFF);
        @(posedge clk); inc <= 2'b10;
        @(posedge clk); inc <= 2'b00;
        @(posedge clk); #1;
        chk(match, 16'h8000);
        chk(ovf_irq, 2'b10);
        $display("Second timer test done");
        @(posedge clk); rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        @(posedge clk); #1;
        chk(pins, 0);
        chk({intr, ovf_irq, match}, 0);
        chk({awr, wr_r, arr, bv, rv}, 5'h1C);
        $display("Reset test done");
        stop_test;
    end
endmodule
